// File: hw/pdc_defs.svh
// Register offsets, field positions, reset values and widths for the pulse/direction counter
`ifndef PDC_DEFS_SVH
`define PDC_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PDC_OFF_CTRL    12'h000
`define PDC_OFF_RELOAD  12'h004
`define PDC_OFF_COUNT   12'h008
`define PDC_OFF_STATUS  12'h00C
`define PDC_OFF_IRQ_EN  12'h010
`define PDC_OFF_RUN     12'h014

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define PDC_CTRL_ENABLE   0
`define PDC_CTRL_RELOAD   1
`define PDC_CTRL_REPEAT   2
`define PDC_CTRL_GATE_EN  3
`define PDC_CTRL_GATE_RISE 4
`define PDC_CTRL_RETRIG   5
`define PDC_CTRL_LOAD     6
`define PDC_CTRL_W        7

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define PDC_ST_OVF  0
`define PDC_ST_UNF  1
`define PDC_ST_W    2

// ----------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------
`define PDC_CNT_W       8
`define PDC_RELOAD_RST  8'h33
`define PDC_CTRL_RST    7'h00
`define PDC_IRQ_EN_RST  2'h0

`endif

// File: hw/pdc_pkg.sv
// Types shared by the pulse/direction counter files
package pdc_pkg;
   typedef enum logic [2:0] {
      PDC_IDLE = 3'b001,
      PDC_WAIT = 3'b010,
      PDC_RUN  = 3'b100
   } pdc_state_t;
endpackage

// File: hw/pdc_pin_sync.sv
// Two-flop synchroniser with edge detection for one input pin
`timescale 1ns/1ps
module pdc_pin_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pin side
   input wire logic pin,
   // Synchronised side
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta;
   logic sync;
   logic prev;
   logic [2:0] fill;

   // Only the second stage reads the first
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b0;
         fill <= 3'h0;
      end else begin
         meta <= pin;
         sync <= meta;
         prev <= sync;
         fill <= {fill[1:0], 1'b1};
      end
   end

   // Edges are masked until the pipeline holds real pin samples, so a pin idling high gives no false edge
   assign level = sync;
   assign rise = sync & ~prev & fill[2];
   assign fall = ~sync & prev & fill[2];
endmodule

// File: hw/pdc_apb_regs.sv
// APB slave: control, reload, interrupt status and mask registers
`timescale 1ns/1ps
`include "pdc_defs.svh"
module pdc_apb_regs import pdc_pkg::*; #(
   parameter int CNT_W = `PDC_CNT_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Counter side
   output logic [`PDC_CTRL_W-1:0] ctrl,
   output logic [CNT_W-1:0] reload_val,
   output logic load_pulse,
   input wire logic [CNT_W-1:0] count,
   input wire logic running,
   input wire logic ovf_evt,
   input wire logic unf_evt,
   // Interrupt
   output logic irq
);
   logic [`PDC_ST_W-1:0] status;
   logic [`PDC_ST_W-1:0] irq_en;
   logic wr;
   logic rd;
   logic [`PDC_ST_W-1:0] events;

   function automatic logic mapped(input logic [11:0] a);
      mapped = (a == `PDC_OFF_CTRL) || (a == `PDC_OFF_RELOAD) || (a == `PDC_OFF_COUNT) ||
               (a == `PDC_OFF_STATUS) || (a == `PDC_OFF_IRQ_EN) || (a == `PDC_OFF_RUN);
   endfunction

   assign wr = psel & penable & pwrite;
   assign rd = psel & ~penable & ~pwrite;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped(paddr);
   assign events = {unf_evt, ovf_evt};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= `PDC_CTRL_RST;
         reload_val <= CNT_W'(`PDC_RELOAD_RST);
         irq_en <= `PDC_IRQ_EN_RST;
      end else if (wr) begin
         if (paddr == `PDC_OFF_CTRL) begin
            ctrl <= pwdata[`PDC_CTRL_W-1:0];
            ctrl[`PDC_CTRL_LOAD] <= 1'b0;
         end
         if (paddr == `PDC_OFF_RELOAD) begin
            reload_val <= pwdata[CNT_W-1:0];
         end
         if (paddr == `PDC_OFF_IRQ_EN) begin
            irq_en <= pwdata[`PDC_ST_W-1:0];
         end
      end
   end

   // Load strobe: a one in the load bit of a control write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         load_pulse <= 1'b0;
      end else begin
         load_pulse <= wr && (paddr == `PDC_OFF_CTRL) && pwdata[`PDC_CTRL_LOAD];
      end
   end

   // A new event beats a write-one-to-clear in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status <= '0;
      end else begin
         if (wr && paddr == `PDC_OFF_STATUS) begin
            status <= (status & ~pwdata[`PDC_ST_W-1:0]) | events;
         end else begin
            status <= status | events;
         end
      end
   end

   // Read data registered in the setup phase, valid in the access phase
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= '0;
      end else if (rd) begin
         case (paddr)
            `PDC_OFF_CTRL: prdata <= 32'(ctrl);
            `PDC_OFF_RELOAD: prdata <= 32'(reload_val);
            `PDC_OFF_COUNT: prdata <= 32'(count);
            `PDC_OFF_STATUS: prdata <= 32'(status);
            `PDC_OFF_IRQ_EN: prdata <= 32'(irq_en);
            `PDC_OFF_RUN: prdata <= 32'(running);
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   assign irq = |(status & irq_en);
endmodule

// File: hw/pdc_counter.sv
// Pulse/direction up/down event counter with gate, reload and count-once control
// Notes on behaviour
// - Each count pulse changes the count by exactly one, except a wrap with reload set, which loads the preset.
// - Direction input level selects increment or decrement per pulse.
// - Counting starts only with enable set; pulses ignored otherwise.
// - Reload and repetitive: wrap loads preset, counting continues.
// - Falling gate, no retrigger: first falling edge starts, later edges ignored.
// - Gate enabled: no counting and value held until gate edge starts it.
// - Falling gate with retrigger: every falling edge restarts counting.
// - Reload and count-once: wrap loads preset, then counting stops.
// - Rising-edge gate option works like falling, on rising edges.
`timescale 1ns/1ps
`include "pdc_defs.svh"
module pdc_counter import pdc_pkg::*; #(
   parameter int CNT_W = `PDC_CNT_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // External pins
   input wire logic count_pulse_input,
   input wire logic direction_input,
   input wire logic gate_input,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Status
   output logic [CNT_W-1:0] count_value,
   output logic overflow,
   output logic underflow,
   output logic irq
);
   logic [`PDC_CTRL_W-1:0] ctrl;
   logic [CNT_W-1:0] reload_val;
   logic load_pulse;
   logic pulse_rise;
   logic dir_up;
   logic gate_rise;
   logic gate_fall;
   logic gate_edge;
   logic enable;
   logic gate_en;
   logic wrap_up;
   logic wrap_dn;
   logic counting;
   pdc_state_t state;
   pdc_state_t next_state;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   pdc_pin_sync u_pulse (
      .clk(clk),
      .rst_n(rst_n),
      .pin(count_pulse_input),
      .level(),
      .rise(pulse_rise),
      .fall()
   );

   pdc_pin_sync u_dir (
      .clk(clk),
      .rst_n(rst_n),
      .pin(direction_input),
      .level(dir_up),
      .rise(),
      .fall()
   );

   pdc_pin_sync u_gate (
      .clk(clk),
      .rst_n(rst_n),
      .pin(gate_input),
      .level(),
      .rise(gate_rise),
      .fall(gate_fall)
   );

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   pdc_apb_regs #(
      .CNT_W(CNT_W)
   ) u_regs (
      .clk(clk),
      .rst_n(rst_n),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .ctrl(ctrl),
      .reload_val(reload_val),
      .load_pulse(load_pulse),
      .count(count_value),
      .running(counting),
      .ovf_evt(overflow),
      .unf_evt(underflow),
      .irq(irq)
   );

   assign enable = ctrl[`PDC_CTRL_ENABLE];
   assign gate_en = ctrl[`PDC_CTRL_GATE_EN];
   // Selected gate edge
   assign gate_edge = ctrl[`PDC_CTRL_GATE_RISE] ? gate_rise : gate_fall;

   // ----------------------------------------------------------------
   // Run control
   // ----------------------------------------------------------------
   // WAIT holds the count until the gate edge; RUN counts pulses
   always_comb begin
      next_state = state;
      case (state)
         PDC_IDLE: begin
            if (enable) begin
               next_state = gate_en ? PDC_WAIT : PDC_RUN;
            end
         end
         PDC_WAIT: begin
            if (!enable) begin
               next_state = PDC_IDLE;
            end else if (gate_en && gate_edge && (!once_done || ctrl[`PDC_CTRL_RETRIG])) begin
               next_state = PDC_RUN;
            end
         end
         PDC_RUN: begin
            if (!enable) begin
               next_state = PDC_IDLE;
            end else if ((wrap_up || wrap_dn) && ctrl[`PDC_CTRL_RELOAD] && !ctrl[`PDC_CTRL_REPEAT]) begin
               // Count-once parks in WAIT so that a retrigger can rearm it
               next_state = PDC_WAIT;
            end
         end
         default: next_state = PDC_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= PDC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   assign counting = (state == PDC_RUN);

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   // A retrigger edge while running reloads and restarts rather than counting
   logic retrig_hit;
   logic once_done;

   assign retrig_hit = enable && gate_en && ctrl[`PDC_CTRL_RETRIG] && gate_edge;
   assign wrap_up = counting && pulse_rise && dir_up && (count_value == {CNT_W{1'b1}});
   assign wrap_dn = counting && pulse_rise && !dir_up && (count_value == '0);

   // Without retrigger a count-once stop is final until enable is cleared
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         once_done <= 1'b0;
      end else if (!enable) begin
         once_done <= 1'b0;
      end else if ((wrap_up || wrap_dn) && ctrl[`PDC_CTRL_RELOAD] && !ctrl[`PDC_CTRL_REPEAT]) begin
         once_done <= 1'b1;
      end else if (retrig_hit) begin
         once_done <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_value <= CNT_W'(`PDC_RELOAD_RST);
      end else if (load_pulse) begin
         count_value <= reload_val;
      end else if (retrig_hit && state != PDC_IDLE && !once_done) begin
         count_value <= reload_val;
      end else if (counting && pulse_rise) begin
         if ((wrap_up || wrap_dn) && ctrl[`PDC_CTRL_RELOAD]) begin
            count_value <= reload_val;
         end else if (dir_up) begin
            count_value <= count_value + 1'b1;
         end else begin
            count_value <= count_value - 1'b1;
         end
      end
   end

   // Flags are one-cycle pulses; the sticky copies live in the status register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         overflow <= 1'b0;
         underflow <= 1'b0;
      end else begin
         overflow <= wrap_up;
         underflow <= wrap_dn;
      end
   end
endmodule

// File: tb/pdc_pulse_src.sv
// Pulse and direction source standing in for an encoder
`timescale 1ns/1ps
module pdc_pulse_src (
   // Clock
   input wire logic clk,
   // Request
   input wire logic start,
   input wire logic up,
   input wire logic [7:0] n,
   // Pins
   output logic pulse,
   output logic dir,
   output logic busy
);
   logic [8:0] left = '0;
   logic [1:0] ph = '0;
   initial begin
      pulse = 1'b0;
      dir = 1'b1;
      busy = 1'b0;
   end
   // Direction settles a full half period before the first edge
   always @(posedge clk) begin
      if (start && !busy) begin
         dir <= up;
         left <= {n, 1'b0};
         ph <= '0;
         busy <= 1'b1;
      end else if (busy) begin
         ph <= ph + 2'h1;
         if (ph == 2'h3) begin
            pulse <= ~pulse;
            left <= left - 9'h001;
            busy <= (left != 9'h001);
         end
      end
   end
endmodule

// File: tb/pdc_counter_chk.sv
// Port-level assertions for the pulse/direction counter
`timescale 1ns/1ps
module pdc_counter_chk #(
   parameter int CNT_W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pins and APB
   input wire logic count_pulse_input,
   input wire logic direction_input,
   input wire logic gate_input,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   // Status
   input wire logic [CNT_W-1:0] count_value,
   input wire logic overflow,
   input wire logic underflow,
   input wire logic irq
);
   logic [7:0] ph;
   logic [7:0] gh;
   logic qp;
   logic qg;
   // Pin histories cover the sync and edge delay with margin
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ph <= 8'h00;
         gh <= 8'h00;
      end else begin
         ph <= {ph[6:0], count_pulse_input};
         gh <= {gh[6:0], gate_input};
      end
   end
   assign qp = (ph == 8'h00) || (ph == 8'hFF);
   assign qg = (gh == 8'h00) || (gh == 8'hFF);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_pready_high: assert property (psel && penable |-> pready) else $error("pready low");
   a_err_access: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
   a_unmapped_err: assert property (psel && penable && paddr > 12'h014 |-> pslverr) else $error("no pslverr");
   a_ovf_wrap: assert property (overflow |-> $past(count_value) == '1 && !underflow) else $error("bad ovf");
   a_unf_wrap: assert property (underflow |-> $past(count_value) == '0) else $error("bad unf");
   a_flag_pulse: assert property (overflow || underflow |=> !overflow && !underflow) else $error("long flag");
   a_step_dir: assert property ($changed(count_value) && !overflow && !underflow && qg
      && !$past(psel && penable && pwrite, 2) |-> count_value == ($past(direction_input, 2)
      ? $past(count_value) + 1'b1 : $past(count_value) - 1'b1)) else $error("bad step");
   a_hold_quiet: assert property (qp && qg && !$past(psel && penable && pwrite, 2) |-> $stable(count_value))
      else $error("count moved");
   a_irq_cause: assert property ($rose(irq) |-> overflow || underflow || $past(overflow || underflow)
      || $past(psel && penable && pwrite)) else $error("irq without cause");
endmodule
bind pdc_counter pdc_counter_chk #(.CNT_W(CNT_W)) u_pdc_counter_chk (.clk(clk), .rst_n(rst_n),
   .count_pulse_input(count_pulse_input), .direction_input(direction_input), .gate_input(gate_input),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .count_value(count_value), .overflow(overflow), .underflow(underflow), .irq(irq));

// File: tb/tb_pdc_counter.sv
// Self-checking bench for the pulse/direction counter
`timescale 1ns/1ps
`include "pdc_defs.svh"
module tb_pdc_counter;
   logic clk, rst_n, psel, penable, pwrite, gate, go, up, pin, dir, busy, er;
   logic pready, pslverr, ovf, unf, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] cv, np;
   int n_errors = 0;
   int check_count = 0;
   pdc_counter u_pdc_counter (.clk(clk), .rst_n(rst_n), .count_pulse_input(pin), .direction_input(dir),
      .gate_input(gate), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .count_value(cv), .overflow(ovf),
      .underflow(unf), .irq(irq));
   pdc_pulse_src u_pdc_pulse_src (.clk(clk), .start(go), .up(up), .n(np), .pulse(pin), .dir(dir),
      .busy(busy));
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic conclude();
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic tmo(input string s);
      chk(s, 32'h1, 32'h0);
      conclude();
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (i == 50) tmo("pready");
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdk(input logic [11:0] a, input logic [31:0] e, input string s);
      apb(1'b0, a, 32'h0);
      chk(s, e, rd);
   endtask
   task automatic ctl(input logic [31:0] d);
      apb(1'b1, `PDC_OFF_CTRL, d);
   endtask
   task automatic rel(input logic [31:0] d);
      apb(1'b1, `PDC_OFF_RELOAD, d);
   endtask
   task automatic pul(input logic [7:0] n, input logic u);
      int i;
      np <= n;
      up <= u;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      for (i = 0; i < 300 && busy === 1'b1; i++) @(posedge clk);
      if (i == 300) tmo("busy");
      repeat (4) @(posedge clk);
   endtask
   task automatic gt(input logic v);
      gate <= v;
      repeat (6) @(posedge clk);
   endtask
   task automatic cnt(input logic [31:0] e);
      chk("count", e, cv);
   endtask
   task automatic t_regs();
      rdk(`PDC_OFF_RELOAD, 32'h33, "reload");
      rdk(`PDC_OFF_COUNT, 32'h33, "count");
      rdk(12'h020, 32'h0, "unmapped");
      chk("slverr", 32'h1, er);
   endtask
   task automatic t_en();
      pul(8'h03, 1'b1);
      cnt(32'h33);
      ctl(32'h01);
      pul(8'h03, 1'b1);
      cnt(32'h36);
      pul(8'h02, 1'b0);
      cnt(32'h34);
   endtask
   task automatic t_rep();
      rel(32'hFE);
      ctl(32'h47);
      rel(32'h33);
      pul(8'h02, 1'b1);
      cnt(32'h33);
      rdk(`PDC_OFF_STATUS, 32'h1, "status");
      chk("irq", 32'h0, irq);
      apb(1'b1, `PDC_OFF_IRQ_EN, 32'h1);
      chk("irq", 32'h1, irq);
      apb(1'b1, `PDC_OFF_STATUS, 32'h1);
      chk("irq", 32'h0, irq);
      pul(8'h01, 1'b1);
      cnt(32'h34);
   endtask
   task automatic t_once();
      rel(32'h00);
      ctl(32'h43);
      rel(32'h33);
      pul(8'h01, 1'b0);
      cnt(32'h33);
      rdk(`PDC_OFF_STATUS, 32'h2, "status");
      chk("irq", 32'h0, irq);
      apb(1'b1, `PDC_OFF_IRQ_EN, 32'h3);
      chk("irq", 32'h1, irq);
      pul(8'h02, 1'b0);
      cnt(32'h33);
      rdk(`PDC_OFF_RUN, 32'h0, "run");
      gt(1'b0);
      gt(1'b1);
      pul(8'h01, 1'b0);
      cnt(32'h33);
   endtask
   task automatic t_fall();
      ctl(32'h00);
      ctl(32'h49);
      pul(8'h02, 1'b1);
      cnt(32'h33);
      gt(1'b0);
      pul(8'h02, 1'b1);
      cnt(32'h35);
      gt(1'b1);
      gt(1'b0);
      pul(8'h01, 1'b1);
      cnt(32'h36);
   endtask
   task automatic t_retrig();
      ctl(32'h00);
      ctl(32'h69);
      gt(1'b1);
      gt(1'b0);
      pul(8'h02, 1'b1);
      cnt(32'h35);
      gt(1'b1);
      gt(1'b0);
      cnt(32'h33);
   endtask
   task automatic t_rise();
      ctl(32'h00);
      ctl(32'h59);
      pul(8'h01, 1'b1);
      cnt(32'h33);
      gt(1'b1);
      pul(8'h01, 1'b1);
      cnt(32'h34);
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      gate = 1'b1;
      go = 1'b0;
      up = 1'b1;
      np = 8'h00;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_regs();
      t_en();
      t_rep();
      t_once();
      t_fall();
      t_retrig();
      t_rise();
      conclude();
   end
endmodule
